// ### rtl/irp_init_top.sv
// power-on and async condition init logic: banks, one-hot and binary machines, latch
`timescale 1ns/1ps
module irp_init_top #(
  parameter irp_pkg::irp_style_t STYLE        = irp_pkg::IRP_FPGA,
  parameter bit                  NO_ASYNC_SET = 1'b0,
  parameter int                  DATA_W       = irp_pkg::IRP_DATA_W,
  parameter int                  FSM_N        = irp_pkg::IRP_FSM_N,
  parameter int                  fsm_start_state_attribute = irp_pkg::IRP_START_IDX,
  parameter logic [DATA_W-1:0]   INIT_S_MASK  = '0
) (
  input  wire logic              core_clk,              // 125 MHz clock
  input  wire logic              rst_n,                 // power-on, sync, active low
  input  wire logic [DATA_W-1:0] data_in,               // register data
  input  wire logic              async_clear_condition, // clear, active high
  input  wire logic              async_set_condition,   // set, active high
  input  wire logic              latch_hold_enable,     // latch enable, active high
  input  wire logic              latch_d_in,            // latch data
  input  wire logic              fsm_reset_in,          // machine reset, active high
  input  wire logic              fsm_step_in,           // machine advance
  output logic      [DATA_W-1:0] clr_bank_q,            // clear-only bank
  output logic      [DATA_W-1:0] set_bank_q,            // set-only bank
  output logic      [DATA_W-1:0] plain_bank_q,          // no-condition bank
  output logic      [DATA_W-1:0] quiet_bank_q,          // set tied to zero
  output logic      [DATA_W-1:0] init_bank_q,           // init-code bank
  output logic                   latch_q,               // transparent latch
  output logic      [FSM_N-1:0]  onehot_q,              // one-hot state
  output logic      [irp_pkg::IRP_BIN_W-1:0] bin_state_q // binary state
);
  import irp_pkg::*;

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (DATA_W < 1) begin : g_bad_w
    $error("DATA_W must be at least one");
  end
  if (FSM_N < 2) begin : g_bad_n
    $error("FSM_N must be at least two");
  end
  if (fsm_start_state_attribute < 0 || fsm_start_state_attribute >= FSM_N) begin : g_bad_s
    $error("start state outside the machine");
  end

  typedef enum logic [IRP_BIN_W-1:0] {
    BIN_IDLE,
    BIN_RUN,
    BIN_WAIT,
    BIN_DONE
  } irp_bin_t;

  localparam logic [FSM_N-1:0] START_VEC = FSM_N'(1) << fsm_start_state_attribute;

  // ------------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------------
  irp_cond_if #(.DW(DATA_W)) cond ();

  irp_sync #(
    .DW (DATA_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .data_in  (data_in),
    .clr_in   (async_clear_condition),
    .set_in   (async_set_condition),
    .le_in    (latch_hold_enable),
    .ld_in    (latch_d_in),
    .rst_in   (fsm_reset_in),
    .step_in  (fsm_step_in),
    .cond     (cond.src)
  );

  logic [DATA_W-1:0] clr_q;
  logic [DATA_W-1:0] set_q;
  logic [DATA_W-1:0] plain_q;
  logic [DATA_W-1:0] quiet_q;
  logic [DATA_W-1:0] init_q;
  logic [FSM_N-1:0]  oh_cur;
  logic [FSM_N-1:0]  oh_next;
  logic              lat_q;
  irp_bin_t          bin_reg;

  // ------------------------------------------------------------------
  // register banks
  // ------------------------------------------------------------------
  for (genvar i = 0; i < DATA_W; i++) begin : g_bank
    irp_cell #(
      .STYLE   (STYLE),
      .HAS_CLR (1'b1),
      .HAS_SET (1'b0),
      .INIT    (IRP_INIT_R),
      .NO_ASET (NO_ASYNC_SET)
    ) u_clr (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (cond.data[i]),
      .clr      (cond.clr),
      .set      (1'b0),
      .q        (clr_q[i])
    );
    irp_cell #(
      .STYLE   (STYLE),
      .HAS_CLR (1'b0),
      .HAS_SET (1'b1),
      .INIT    (IRP_INIT_R),
      .NO_ASET (NO_ASYNC_SET)
    ) u_set (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (cond.data[i]),
      .clr      (1'b0),
      .set      (cond.set),
      .q        (set_q[i])
    );
    irp_cell #(
      .STYLE   (STYLE),
      .HAS_CLR (1'b0),
      .HAS_SET (1'b0),
      .INIT    (IRP_INIT_R),
      .NO_ASET (NO_ASYNC_SET)
    ) u_plain (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (cond.data[i]),
      .clr      (1'b0),
      .set      (1'b0),
      .q        (plain_q[i])
    );
    // set present but tied low: power-on value only
    irp_cell #(
      .STYLE   (STYLE),
      .HAS_CLR (1'b0),
      .HAS_SET (1'b1),
      .INIT    (IRP_INIT_R),
      .NO_ASET (NO_ASYNC_SET)
    ) u_quiet (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (cond.data[i]),
      .clr      (1'b0),
      .set      (1'b0),
      .q        (quiet_q[i])
    );
    irp_cell #(
      .STYLE   (STYLE),
      .HAS_CLR (STYLE == IRP_CPLD),
      .HAS_SET (1'b1),
      .INIT    (INIT_S_MASK[i] ? IRP_INIT_S : IRP_INIT_R),
      .NO_ASET (NO_ASYNC_SET)
    ) u_init (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (cond.data[i]),
      .clr      (cond.clr),
      .set      (cond.set),
      .q        (init_q[i])
    );
  end

  // ------------------------------------------------------------------
  // one-hot machine
  // ------------------------------------------------------------------
  assign oh_next = cond.fsm_step ? {oh_cur[FSM_N-2:0], oh_cur[FSM_N-1]} : oh_cur;

  for (genvar s = 0; s < FSM_N; s++) begin : g_oh
    localparam bit IS_START = (s == fsm_start_state_attribute);
    irp_cell #(
      .STYLE   (STYLE),
      .HAS_CLR (!IS_START),
      .HAS_SET (IS_START),
      .INIT    (IS_START ? IRP_INIT_S : IRP_INIT_R),
      .NO_ASET (NO_ASYNC_SET)
    ) u_state (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (oh_next[s]),
      .clr      (cond.fsm_rst),
      .set      (cond.fsm_rst),
      .q        (oh_cur[s])
    );
  end

  // ------------------------------------------------------------------
  // binary machine
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bin_reg <= BIN_IDLE;
    end else if (cond.fsm_rst) begin
      bin_reg <= BIN_IDLE;
    end else if (cond.fsm_step) begin
      case (bin_reg)
        BIN_IDLE: bin_reg <= BIN_RUN;
        BIN_RUN:  bin_reg <= BIN_WAIT;
        BIN_WAIT: bin_reg <= BIN_DONE;
        BIN_DONE: bin_reg <= BIN_IDLE;
        default:  bin_reg <= BIN_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // transparent latch
  // ------------------------------------------------------------------
  if (STYLE == IRP_CPLD) begin : g_lat_cpld
    // held clock: data path only recirculates, conditions do the work
    irp_cell #(
      .STYLE   (STYLE),
      .HAS_CLR (1'b1),
      .HAS_SET (1'b1),
      .INIT    (IRP_INIT_R),
      .NO_ASET (NO_ASYNC_SET)
    ) transparent_latch_primitive (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (lat_q),
      .clr      (~cond.ld & cond.le),
      .set      (cond.ld & cond.le),
      .q        (lat_q)
    );
  end else begin : g_lat_fpga
    irp_cell #(
      .STYLE   (STYLE),
      .HAS_CLR (1'b0),
      .HAS_SET (1'b0),
      .INIT    (IRP_INIT_R),
      .NO_ASET (NO_ASYNC_SET)
    ) transparent_latch_primitive (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (cond.le ? cond.ld : lat_q),
      .clr      (1'b0),
      .set      (1'b0),
      .q        (lat_q)
    );
  end

  // ------------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clr_bank_q   <= '0;
      set_bank_q   <= '0;
      plain_bank_q <= '0;
      quiet_bank_q <= '0;
      init_bank_q  <= '0;
      latch_q      <= 1'b0;
      onehot_q     <= '0;
      bin_state_q  <= '0;
    end else begin
      clr_bank_q   <= clr_q;
      set_bank_q   <= set_q;
      plain_bank_q <= plain_q;
      quiet_bank_q <= quiet_q;
      init_bank_q  <= init_q;
      latch_q      <= lat_q;
      onehot_q     <= oh_cur;
      bin_state_q  <= bin_reg;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_clr_powerup: assert property ($rose(rst_n) |-> clr_q == '0)
    else $error("clear bank not zero at power-on");

  chk_set_powerup: assert property (
    $rose(rst_n) |-> set_q == ((STYLE == IRP_FPGA) ? {DATA_W{1'b1}} : {DATA_W{1'b0}}))
    else $error("set bank wrong at power-on");

  chk_plain_powerup: assert property ($rose(rst_n) |-> plain_q == '0)
    else $error("plain bank not zero at power-on");

  chk_quiet_follow: assert property ($past(rst_n) |-> quiet_q == $past(cond.data))
    else $error("quiet bank was forced");

  chk_init_mask: assert property (
    $rose(rst_n) && STYLE == IRP_CPLD |-> init_q == INIT_S_MASK)
    else $error("init bank does not match init codes");

  chk_onehot_legal: assert property ($onehot(oh_cur))
    else $error("one-hot machine in illegal state");

  chk_onehot_start: assert property ($rose(rst_n) |-> oh_cur == START_VEC)
    else $error("one-hot machine not at start after power-on");

  chk_fsm_reset: assert property (cond.fsm_rst |=> oh_cur == START_VEC)
    else $error("one-hot reset missed start state");

  chk_bin_clear: assert property (cond.fsm_rst |=> bin_reg == BIN_IDLE)
    else $error("binary machine not cleared");

  chk_latch_track: assert property (cond.le |=> lat_q == $past(cond.ld))
    else $error("open latch did not follow data");

  chk_latch_hold: assert property (!cond.le |=> $stable(lat_q))
    else $error("closed latch changed");

  cov_fsm_reset: cover property (cond.fsm_step ##1 cond.fsm_rst ##1 oh_cur == START_VEC);
  cov_latch_cap: cover property (cond.le && cond.ld ##1 !cond.le ##1 lat_q);
  cov_bin_wrap:  cover property (bin_reg == BIN_DONE && cond.fsm_step);
  cov_clr_hit:   cover property (cond.clr ##1 clr_q == '0);
endmodule

// ### pkg/irp_pkg.sv
// shared constants and types for the register power-on init block
package irp_pkg;

  typedef enum logic {IRP_FPGA, IRP_CPLD} irp_style_t;
  typedef enum logic {IRP_INIT_R, IRP_INIT_S} irp_init_t;

  localparam int IRP_SYNC_STAGES = 2;
  localparam int IRP_COND_BITS   = 6;
  localparam int IRP_DATA_W      = 8;
  localparam int IRP_FSM_N       = 4;
  localparam int IRP_START_IDX   = 0;
  localparam int IRP_BIN_W       = 2;

endpackage

// ### pkg/irp_cond_if.sv
// synchronised data and condition bundle between the input stage and the core
`timescale 1ns/1ps
interface irp_cond_if #(
  parameter int DW = 8
);
  logic [DW-1:0] data;
  logic          clr;
  logic          set;
  logic          le;
  logic          ld;
  logic          fsm_rst;
  logic          fsm_step;

  modport src (output data, clr, set, le, ld, fsm_rst, fsm_step);
  modport dst (input data, clr, set, le, ld, fsm_rst, fsm_step);
endinterface

// ### rtl/irp_sync.sv
// two-stage synchroniser for every data and condition pin input of the block
`timescale 1ns/1ps
module irp_sync #(
  parameter int DW = irp_pkg::IRP_DATA_W
) (
  input  wire logic          core_clk,   // block clock
  input  wire logic          rst_n,      // sync reset, active low
  input  wire logic [DW-1:0] data_in,    // raw data pins
  input  wire logic          clr_in,     // raw clear condition
  input  wire logic          set_in,     // raw set condition
  input  wire logic          le_in,      // raw latch enable
  input  wire logic          ld_in,      // raw latch data
  input  wire logic          rst_in,     // raw machine reset condition
  input  wire logic          step_in,    // raw machine advance
  irp_cond_if.src            cond        // synchronised outputs
);
  import irp_pkg::*;

  localparam int N = DW + IRP_COND_BITS;

  logic [N-1:0] raw;
  logic [N-1:0] meta_reg;
  logic [N-1:0] sync_reg;

  assign raw = {data_in, clr_in, set_in, le_in, ld_in, rst_in, step_in};

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= raw;
      sync_reg <= meta_reg;
    end
  end

  assign {cond.data, cond.clr, cond.set, cond.le, cond.ld, cond.fsm_rst, cond.fsm_step} = sync_reg;
endmodule

// ### rtl/irp_cell.sv
// one configurable register with power-on value and clear/set conditions
`timescale 1ns/1ps
module irp_cell #(
  parameter irp_pkg::irp_style_t STYLE   = irp_pkg::IRP_FPGA,
  parameter bit                  HAS_CLR = 1'b0,
  parameter bit                  HAS_SET = 1'b0,
  parameter irp_pkg::irp_init_t  INIT    = irp_pkg::IRP_INIT_R,
  parameter bit                  NO_ASET = 1'b0
) (
  input  wire logic core_clk,  // block clock
  input  wire logic rst_n,     // power-on reset, active low
  input  wire logic d,         // data
  input  wire logic clr,       // clear condition, active high
  input  wire logic set,       // set condition, active high
  output logic      q          // logical value
);
  import irp_pkg::*;

  // inverted store only where a set is wanted but the family lacks it
  localparam bit INV = (STYLE == IRP_FPGA) && HAS_SET && NO_ASET;
  // power-on follows the async condition in fpga, the init code in cpld
  localparam bit PON = (STYLE == IRP_CPLD) ?
                       (INIT == IRP_INIT_S) :
                       HAS_SET;
  localparam bit STORE_PON = PON ^ INV;

  if (STYLE == IRP_FPGA && HAS_CLR && HAS_SET) begin : g_bad_pair
    $error("fpga style cell cannot carry clear and set together");
  end
  if (INV && HAS_CLR) begin : g_bad_inv
    $error("inverted cell has no clear left");
  end

  logic store_reg;
  logic clr_eff;
  logic set_eff;

  assign clr_eff = HAS_CLR & clr;
  assign set_eff = HAS_SET & set;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      store_reg <= STORE_PON;
    end else if (INV) begin
      if (set_eff) begin
        store_reg <= 1'b0;
      end else begin
        store_reg <= ~d;
      end
    end else if (clr_eff) begin
      store_reg <= 1'b0;
    end else if (set_eff) begin
      store_reg <= 1'b1;
    end else begin
      store_reg <= d;
    end
  end

  assign q = store_reg ^ INV;

  chk_cell_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    clr_eff |=> q == 1'b0)
    else $error("cleared cell did not read zero");
endmodule

// ### tb/irp_user_model.sv
// surrounding user logic model: drives the block's pins at the falling edge
`timescale 1ns/1ps
module irp_user_model (
  input  wire logic       core_clk,  // block clock
  input  wire logic [7:0] req_data,  // requested data level
  input  wire logic [5:0] req_ctl,   // {step,rst,ld,le,set,clr}
  output logic      [7:0] data_out,  // data pins
  output logic      [5:0] ctl_out    // condition pins
);
  // levels change only away from the sampling edge
  always @(negedge core_clk) begin
    data_out <= req_data;
    ctl_out  <= req_ctl;
  end
endmodule

// ### tb/tb.sv
// self-checking bench for the power-on init block in both styles
`timescale 1ns/1ps
module tb;
  import irp_pkg::*;

  logic       core_clk;
  logic       rst_n;
  logic [7:0] req_data;
  logic [5:0] req_ctl;
  logic [7:0] pin_data;
  logic [5:0] pin_ctl;
  logic [7:0] f_clr, f_set, f_plain, f_quiet, f_init;
  logic [7:0] c_clr, c_set, c_plain, c_quiet, c_init;
  logic       f_lat, c_lat;
  logic [7:0] a_set;
  logic [3:0] f_oh, c_oh, a_oh;
  logic [1:0] f_bin, c_bin;
  int         mismatches;
  int         compares;

  initial begin
    core_clk   = 1'b0;
    rst_n      = 1'b0;
    req_data   = 8'h00;
    req_ctl    = 6'h00;
    mismatches = 0;
    compares   = 0;
  end

  always #4 core_clk = ~core_clk;

  irp_user_model i_user (.core_clk(core_clk), .req_data(req_data), .req_ctl(req_ctl),
                         .data_out(pin_data), .ctl_out(pin_ctl));

  // fpga style without async set: power-on ones come from inverted storage
  irp_init_top #(.STYLE(IRP_FPGA), .NO_ASYNC_SET(1'b1), .fsm_start_state_attribute(2))
    i_dut (.core_clk(core_clk), .rst_n(rst_n), .data_in(pin_data),
           .async_clear_condition(pin_ctl[0]), .async_set_condition(pin_ctl[1]),
           .latch_hold_enable(pin_ctl[2]), .latch_d_in(pin_ctl[3]),
           .fsm_reset_in(pin_ctl[4]), .fsm_step_in(pin_ctl[5]),
           .clr_bank_q(f_clr), .set_bank_q(f_set), .plain_bank_q(f_plain),
           .quiet_bank_q(f_quiet), .init_bank_q(f_init), .latch_q(f_lat),
           .onehot_q(f_oh), .bin_state_q(f_bin));

  irp_init_top #(.STYLE(IRP_CPLD), .INIT_S_MASK(8'hA5), .fsm_start_state_attribute(2))
    i_dut_cpld (.core_clk(core_clk), .rst_n(rst_n), .data_in(pin_data),
                .async_clear_condition(pin_ctl[0]), .async_set_condition(pin_ctl[1]),
                .latch_hold_enable(pin_ctl[2]), .latch_d_in(pin_ctl[3]),
                .fsm_reset_in(pin_ctl[4]), .fsm_step_in(pin_ctl[5]),
                .clr_bank_q(c_clr), .set_bank_q(c_set), .plain_bank_q(c_plain),
                .quiet_bank_q(c_quiet), .init_bank_q(c_init), .latch_q(c_lat),
                .onehot_q(c_oh), .bin_state_q(c_bin));

  // fpga style with a true async set: set bank and start flip-flop use it directly
  irp_init_top #(.STYLE(IRP_FPGA), .fsm_start_state_attribute(2))
    i_dut_aset (.core_clk(core_clk), .rst_n(rst_n), .data_in(pin_data),
                .async_clear_condition(pin_ctl[0]), .async_set_condition(pin_ctl[1]),
                .latch_hold_enable(pin_ctl[2]), .latch_d_in(pin_ctl[3]),
                .fsm_reset_in(pin_ctl[4]), .fsm_step_in(pin_ctl[5]),
                .clr_bank_q(), .set_bank_q(a_set), .plain_bank_q(),
                .quiet_bank_q(), .init_bank_q(), .latch_q(),
                .onehot_q(a_oh), .bin_state_q());

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request pin levels, then wait past the four-cycle path
  task drive(input logic [7:0] d, input logic [5:0] c);
    @(posedge core_clk);
    req_data <= d;
    req_ctl  <= c;
    repeat (7) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // data differs from every power-on value while reset is held
  task t_power_on;
    @(posedge core_clk);
    req_data <= 8'h5A;
    req_ctl  <= 6'h00;
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk8(f_clr, 8'h00);
    chk8(f_set, 8'hFF);
    chk8(f_plain, 8'h00);
    chk8(f_quiet, 8'hFF);
    chk8(f_init, 8'hFF);
    chk8({4'h0, f_oh}, 8'h04);
    chk8(c_clr, 8'h00);
    chk8(c_set, 8'h00);
    chk8(c_quiet, 8'h00);
    chk8(c_init, 8'hA5);
    chk8({4'h0, c_oh}, 8'h04);
    chk8(c_plain, 8'h00);
    chk8({6'h00, f_bin}, 8'h00);
    chk8(a_set, 8'hFF);
    chk8({4'h0, a_oh}, 8'h04);
    chk8({6'h00, c_bin}, 8'h00);
    $display("test power_on done");
  endtask

  task t_conditions;
    drive(8'h3C, 6'h00);
    chk8(f_plain, 8'h3C);
    chk8(f_quiet, 8'h3C);
    chk8(c_set, 8'h3C);
    chk8(c_plain, 8'h3C);
    drive(8'h3C, 6'h01);
    chk8(f_clr, 8'h00);
    chk8(c_clr, 8'h00);
    chk8(c_init, 8'h00);
    chk8(f_set, 8'h3C);
    drive(8'h3C, 6'h03);
    chk8(c_init, 8'h00);
    chk8(f_set, 8'hFF);
    chk8(c_set, 8'hFF);
    chk8(a_set, 8'hFF);
    drive(8'h3C, 6'h02);
    chk8(c_init, 8'hFF);
    chk8(f_clr, 8'h3C);
    chk8(f_quiet, 8'h3C);
    drive(8'h3C, 6'h00);
    $display("test conditions done");
  endtask

  task t_machines;
    @(posedge core_clk);
    req_ctl <= 6'h20;
    // five steps: the binary machine wraps past its last state
    repeat (5) @(posedge core_clk);
    req_ctl <= 6'h00;
    repeat (7) @(posedge core_clk);
    @(negedge core_clk);
    chk8({4'h0, f_oh}, 8'h08);
    chk8({4'h0, c_oh}, 8'h08);
    chk8({4'h0, a_oh}, 8'h08);
    chk8({6'h00, c_bin}, 8'h01);
    chk8({6'h00, f_bin}, 8'h01);
    drive(8'h3C, 6'h10);
    chk8({4'h0, f_oh}, 8'h04);
    chk8({4'h0, c_oh}, 8'h04);
    chk8({4'h0, a_oh}, 8'h04);
    chk8({6'h00, c_bin}, 8'h00);
    chk8({6'h00, f_bin}, 8'h00);
    drive(8'h3C, 6'h00);
    $display("test machines done");
  endtask

  task t_latch;
    drive(8'h3C, 6'h0C);
    chk8({7'h00, c_lat}, 8'h01);
    chk8({7'h00, f_lat}, 8'h01);
    drive(8'h3C, 6'h00);
    chk8({7'h00, c_lat}, 8'h01);
    drive(8'h3C, 6'h04);
    chk8({7'h00, c_lat}, 8'h00);
    drive(8'h3C, 6'h08);
    chk8({7'h00, c_lat}, 8'h00);
    chk8({7'h00, f_lat}, 8'h00);
    $display("test latch done");
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_power_on;
    t_conditions;
    t_machines;
    t_latch;
    t_power_on;
    conclude;
  end

  initial begin
    #40000;
    mismatches++;
    conclude;
  end
endmodule
